// ===== secure_memory_access_flags.v
// Summary of operation
// - compare 16 presented code bits to stored bits 80..95 per clock
// - match plus correct validation drives one on data and sets valid flag
// - validation erase restores all 16 attempt counter bits
// - valid flag stays set until power loss
// - mismatch or bad validation outputs zero, flag is left unchanged
// - eight consecutive failures lock the card for good
// - valid flag is the master access qualifier
// - zone one write flag set when bit 176 addressed holding one
// - zone one flags hold until power loss
// - zone one read flag set when bit 177 addressed holding one
// - mode two zone one write needs write flag and valid flag
// - zone one read allowed by read flag or valid flag
// - issuer fuse one selects mode one, zero selects mode two
`timescale 1ns/1ns
`include "smaf_map.vh"
module secure_memory_access_flags (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire card_clk_i,
   input wire addr_reset_i,
   input wire pgm_i,
   input wire io_i,
   input wire mem_bit_i,
   input wire issuer_fuse_i,
   output reg [`ADDR_W-1:0] addr_o,
   output reg io_o,
   output reg io_oe_o,
   output reg mem_write_o,
   output reg mem_erase_o,
   output reg security_valid_flag_o,
   output reg zone1_write_flag_o,
   output reg zone1_read_flag_o,
   output reg security_mode2_o,
   output reg first_app_zone_write_en_o,
   output reg first_app_zone_read_en_o,
   output reg locked_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: a level counts once stages two and three agree
// each pin level must stand at least two cycles to be seen
reg [`PIN_N-1:0] sync1_q;
reg [`PIN_N-1:0] sync2_q;
reg [`PIN_N-1:0] sync3_q;
reg [`PIN_N-1:0] pin_q;
integer i;

always @(posedge clk_sys_i or negedge resetn_i) begin
   if (!resetn_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      pin_q <= 4'h0;
   end else begin
      sync1_q <= {io_i, pgm_i, addr_reset_i, card_clk_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (i = 0; i < `PIN_N; i = i + 1) begin
         if (sync2_q[i] == sync3_q[i]) begin
            pin_q[i] <= sync3_q[i];
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// edge events on filtered pins
// pins idle low, so the zero reset of the history cannot fake an edge
reg [`PIN_N-1:0] pin_prev_q;
wire clk_rise = pin_q[`PIN_CLK] & ~pin_prev_q[`PIN_CLK];
wire pgm_rise = pin_q[`PIN_PGM] & ~pin_prev_q[`PIN_PGM];
wire rst_level = pin_q[`PIN_RST];
wire io_level = pin_q[`PIN_IO];
wire bit_match = (io_level == mem_bit_i);

always @(posedge clk_sys_i or negedge resetn_i) begin
   if (!resetn_i) begin
      pin_prev_q <= 4'h0;
   end else begin
      pin_prev_q <= pin_q;
   end
end

////////////////////////////////////////////////////////////////////////////////
// address decode
wire in_code = (addr_o >= `CODE_FIRST) && (addr_o <= `CODE_LAST);
wire in_att8 = (addr_o >= `ATTEMPT_FIRST) && (addr_o <= `ATTEMPT_LAST8);
wire in_att = (addr_o >= `ATTEMPT_FIRST) && (addr_o <= `ATTEMPT_LAST);

////////////////////////////////////////////////////////////////////////////////
// validation sequencer
// idle: nothing pending; cmp: code bits arriving; val: code done,
// counter bit not yet written; wrote: counter bit written, erase pending
localparam ST_IDLE = 2'h0;
localparam ST_CMP = 2'h1;
localparam ST_VAL = 2'h2;
localparam ST_WROTE = 2'h3;

// failure run and scan history survive address resets
reg [1:0] state_q;
reg match_q;
reg seen_one_q;
reg [3:0] fail_cnt_q;
wire erase_ok = (state_q == ST_WROTE) && match_q && !locked_o;
wire fail_limit = (fail_cnt_q + 4'h1 >= `MAX_FAILS);

always @(posedge clk_sys_i or negedge resetn_i) begin
   if (!resetn_i) begin
      addr_o <= 10'h000;
      state_q <= ST_IDLE;
      match_q <= 1'b0;
      seen_one_q <= 1'b0;
      fail_cnt_q <= 4'h0;
      locked_o <= 1'b0;
      security_valid_flag_o <= 1'b0;
      zone1_write_flag_o <= 1'b0;
      zone1_read_flag_o <= 1'b0;
      io_o <= 1'b0;
      io_oe_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_erase_o <= 1'b0;
   end else begin
      mem_write_o <= 1'b0;
      mem_erase_o <= 1'b0;
      // flags latch while their bit is addressed and holds one
      if (addr_o == `Z1_WRITE_BIT && mem_bit_i) begin
         zone1_write_flag_o <= 1'b1;
      end
      if (addr_o == `Z1_READ_BIT && mem_bit_i) begin
         zone1_read_flag_o <= 1'b1;
      end
      // address reset aborts validation and releases the data line
      if (rst_level) begin
         addr_o <= 10'h000;
         state_q <= ST_IDLE;
         io_oe_o <= 1'b0;
      end else if (clk_rise) begin
         addr_o <= addr_o + 10'h001;
         io_oe_o <= 1'b0;
         if (addr_o == `CODE_FIRST) begin
            state_q <= ST_CMP;
            match_q <= bit_match;
            seen_one_q <= 1'b0;
         end else if (in_code && state_q == ST_CMP) begin
            match_q <= match_q & bit_match;
            if (addr_o == `CODE_LAST) begin
               state_q <= ST_VAL;
            end
         end else if (in_att8) begin
            if (mem_bit_i) begin
               seen_one_q <= 1'b1;
            end
            // a scan of counter bits 96..103 with no usable counter bit blocks the card
            if (addr_o == `ATTEMPT_LAST8 && !seen_one_q && !mem_bit_i
                  && state_q != ST_WROTE) begin
               locked_o <= 1'b1;
            end
         end else if (!in_att) begin
            state_q <= ST_IDLE;
         end
      end else if (pgm_rise) begin
         if (!io_level) begin
            mem_write_o <= 1'b1;
            // the written bit must have held one, else validation is abandoned
            if (state_q == ST_VAL && in_att8 && mem_bit_i && !locked_o) begin
               state_q <= ST_WROTE;
            end else if (state_q != ST_WROTE) begin
               state_q <= ST_IDLE;
            end
         end else begin
            io_oe_o <= 1'b1;
            state_q <= ST_IDLE;
            // erase only after a matching code, else the written counter bit stays
            if (erase_ok && in_att) begin
               mem_erase_o <= 1'b1;
               security_valid_flag_o <= 1'b1;
               io_o <= 1'b1;
               // a pass clears the run of failures
               fail_cnt_q <= 4'h0;
            end else begin
               io_o <= 1'b0;
               // only an attempt that reached the counter counts as a failure
               if (state_q == ST_VAL || state_q == ST_WROTE) begin
                  // eighth consecutive failure locks for good
                  if (fail_limit) begin
                     locked_o <= 1'b1;
                  end
                  // saturate so the count never wraps below the limit
                  if (fail_cnt_q < `MAX_FAILS) begin
                     fail_cnt_q <= fail_cnt_q + 4'h1;
                  end
               end
            end
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// access qualifiers
// qualifiers follow the flags one cycle later
always @(posedge clk_sys_i or negedge resetn_i) begin
   if (!resetn_i) begin
      security_mode2_o <= 1'b0;
      first_app_zone_write_en_o <= 1'b0;
      first_app_zone_read_en_o <= 1'b0;
   end else begin
      security_mode2_o <= ~issuer_fuse_i;
      if (!issuer_fuse_i) begin
         first_app_zone_write_en_o <= zone1_write_flag_o & security_valid_flag_o;
      end else begin
         first_app_zone_write_en_o <= security_valid_flag_o;
      end
      first_app_zone_read_en_o <= zone1_read_flag_o | security_valid_flag_o;
   end
end

endmodule // secure_memory_access_flags

// ===== smaf_map.vh
`ifndef SMAF_MAP_VH
`define SMAF_MAP_VH
// address counter width and key bit addresses
`define ADDR_W 10
`define CODE_FIRST 10'h050
`define CODE_LAST 10'h05f
`define ATTEMPT_FIRST 10'h060
`define ATTEMPT_LAST8 10'h067
`define ATTEMPT_LAST 10'h06f
`define Z1_WRITE_BIT 10'h0b0
`define Z1_READ_BIT 10'h0b1
// consecutive failed presentations before permanent lock
`define MAX_FAILS 4'h8
// pin synchroniser slots
`define PIN_CLK 0
`define PIN_RST 1
`define PIN_PGM 2
`define PIN_IO 3
`define PIN_N 4
`endif

// ===== smaf_mem.sv
`timescale 1ns/1ns
`include "smaf_map.vh"
module smaf_mem (
   input wire clk_sys_i,
   input wire [`ADDR_W-1:0] addr_i,
   input wire write_i,
   input wire erase_i,
   output wire bit_o
);
   reg [1023:0] mem_q;
   assign bit_o = mem_q[addr_i];
   always @(posedge clk_sys_i) begin
      if (write_i) mem_q[addr_i] <= 1'b0;
      if (erase_i) mem_q[111:96] <= 16'hffff;
   end
endmodule // smaf_mem

// ===== smaf_sva.sv
`timescale 1ns/1ns
`include "smaf_map.vh"
module smaf_sva (
   input wire clk_sys_i,
   input wire resetn_i,
   input wire mem_bit_i,
   input wire issuer_fuse_i,
   input wire [`ADDR_W-1:0] addr_o,
   input wire io_o,
   input wire mem_erase_o,
   input wire security_valid_flag_o,
   input wire zone1_write_flag_o,
   input wire zone1_read_flag_o,
   input wire first_app_zone_write_en_o,
   input wire first_app_zone_read_en_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence pass_ack;
      mem_erase_o && io_o;
   endsequence
   sequence flags_clear;
      !(security_valid_flag_o || zone1_write_flag_o || zone1_read_flag_o);
   endsequence
   flags_clear_a: assert property ($rose(resetn_i) |-> flags_clear)
      else $error("flag set at power up");
   valid_hold_a: assert property (security_valid_flag_o |=> security_valid_flag_o)
      else $error("valid flag dropped");
   wr_hold_a: assert property (zone1_write_flag_o |=> zone1_write_flag_o)
      else $error("write flag dropped");
   rd_hold_a: assert property (zone1_read_flag_o |=> zone1_read_flag_o)
      else $error("read flag dropped");
   rd_set_a: assert property (addr_o == `Z1_READ_BIT && mem_bit_i |=> zone1_read_flag_o)
      else $error("read flag not set");
   wr_set_a: assert property (addr_o == `Z1_WRITE_BIT && mem_bit_i |=> zone1_write_flag_o)
      else $error("write flag not set");
   valid_ack_a: assert property ($rose(security_valid_flag_o) |-> pass_ack)
      else $error("valid flag without erase and ack");
   rd_en_a: assert property (first_app_zone_read_en_o ==
      ($past(zone1_read_flag_o) | $past(security_valid_flag_o)))
      else $error("read enable wrong");
   wr_en_a: assert property (first_app_zone_write_en_o ==
      ($past(security_valid_flag_o) & ($past(issuer_fuse_i) | $past(zone1_write_flag_o))))
      else $error("write enable wrong");
endmodule // smaf_sva
bind secure_memory_access_flags smaf_sva sva_i (.*);

// ===== tb_top.sv
`timescale 1ns/1ns
`include "smaf_map.vh"
module tb_top;
   reg clk_sys_i = 0, resetn_i = 0, card_clk_i = 0, addr_reset_i = 0, pgm_i = 0, io_i = 0;
   reg issuer_fuse_i = 0, valid_exp = 0, ok = 0, lock_exp = 0;
   reg [15:0] code;
   wire [`ADDR_W-1:0] addr_o;
   wire mem_bit_i, io_o, io_oe_o, mem_write_o, mem_erase_o, security_valid_flag_o, locked_o;
   wire zone1_write_flag_o, zone1_read_flag_o, security_mode2_o;
   wire first_app_zone_write_en_o, first_app_zone_read_en_o;
   integer num_errors = 0, n_compared = 0, fails = 0, i, j;
   secure_memory_access_flags DUT (.*);
   smaf_mem mem (.clk_sys_i, .addr_i(addr_o), .write_i(mem_write_o), .erase_i(mem_erase_o),
      .bit_o(mem_bit_i));
   initial forever #5 clk_sys_i = ~clk_sys_i;
   ////////////////////
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task hold(input integer n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task pulse(input b, input p);
      begin
         io_i <= b;
         hold(5);
         if (p) pgm_i <= 1; else card_clk_i <= 1;
         hold(6);
         pgm_i <= 0;
         card_clk_i <= 0;
         hold(6);
      end
   endtask
   // one code presentation, counter bit 96+k used
   task attempt(input bad, input integer k);
      begin
         addr_reset_i <= 1;
         hold(6);
         addr_reset_i <= 0;
         for (j = 0; j < 96 + k; j = j + 1) pulse(j > 79 && code[j-80] ^ (bad && j == 80), 0);
         pulse(0, 1);
         pulse(1, 1);
         ok = !bad && k < 8 && !lock_exp;
         fails = ok ? 0 : fails + 1;
         lock_exp = lock_exp | (fails > 7) | (k > 7 && mem.mem_q[103:96] == 8'h00);
         valid_exp = valid_exp | ok;
         chk(security_valid_flag_o, valid_exp);
         chk(io_o, ok);
         chk(io_oe_o, 1);
         chk(addr_o, 16'(96 + k));
         chk(locked_o, lock_exp);
         chk(first_app_zone_read_en_o, valid_exp);
      end
   endtask
   // power loss: flags clear, attempt counter word preset to att
   task power_cycle(input [15:0] att);
      begin
         resetn_i <= 0;
         hold(2);
         resetn_i <= 1;
         mem.mem_q[111:96] = att;
         fails = 0;
         valid_exp = 0;
         lock_exp = 0;
         hold(4);
         chk(security_valid_flag_o, 0);
         chk(zone1_write_flag_o, 0);
         chk(zone1_read_flag_o, 0);
         chk(first_app_zone_read_en_o, 0);
      end
   endtask
   task test_done;
      begin
         $display("errors=%0d compared=%0d", num_errors, n_compared);
         if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   ////////////////////
   initial begin
      j = $urandom(32'h0d97);
      code = 16'($urandom);
      issuer_fuse_i <= 1'($urandom);
      mem.mem_q = {1024{1'b1}};
      mem.mem_q[95:80] = code;
      hold(12);
      resetn_i <= 1;
      hold(4);
      for (i = 0; i < 8; i = i + 1) begin
         attempt(1, i);
         chk(mem.mem_q[111:96], 16'hffff << (i + 1));
      end
      attempt(0, 8);
      for (j = 104; j < 178; j = j + 1) pulse(0, 0);
      chk(zone1_write_flag_o, 1);
      chk(zone1_read_flag_o, 1);
      chk(first_app_zone_read_en_o, 1);
      chk(first_app_zone_write_en_o, 0);
      power_cycle(16'hff00);
      attempt(0, 8);
      power_cycle(16'hffff);
      attempt(0, 0);
      chk(mem.mem_q[111:96], 16'hffff);
      chk(first_app_zone_write_en_o, issuer_fuse_i);
      chk(security_mode2_o, !issuer_fuse_i);
      issuer_fuse_i <= !issuer_fuse_i;
      hold(3);
      chk(first_app_zone_write_en_o, issuer_fuse_i);
      chk(security_mode2_o, !issuer_fuse_i);
      for (j = 96; j < 178; j = j + 1) begin
         if (j == 177) pulse(0, 1);
         pulse(0, 0);
      end
      chk(mem.mem_q[177], 0);
      chk(zone1_write_flag_o, 1);
      chk(zone1_read_flag_o, 1);
      chk(first_app_zone_write_en_o, 1);
      test_done;
   end
endmodule // tb_top
